//--- coss_consts.vh
// Constants for the contact output status selector: bus map, field
// widths, status source codes and pulse timing.
// Assumes a 20 MHz system clock and word-only AHB-Lite accesses.
`ifndef COSS_CONSTS_VH
`define COSS_CONSTS_VH

// ----------------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------------
`define COSS_ADDR_W          12
`define COSS_SEL_BASE        12'h000
`define COSS_SEL_LAST        12'h060
`define COSS_POL_ADDR        12'h080
`define COSS_CONTACT_ADDR    12'h084
`define COSS_SRC_LO_ADDR     12'h088
`define COSS_SRC_HI_ADDR     12'h08c
`define COSS_CTRL_ADDR       12'h090

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define COSS_CODE_W          13
`define COSS_NUM_OUT         25
`define COSS_NUM_SRC         50
`define COSS_SEL_RESET       13'h0000
`define COSS_POL_RESET       25'h000_0000
`define COSS_CTRL_RESET      6'h00

// ----------------------------------------------------------------------
// Status source codes
// ----------------------------------------------------------------------
`define COSS_PV_EV1          13'h12b1
`define COSS_PV_EV2          13'h12b2
`define COSS_PV_OUT1         13'h12c1
`define COSS_PV_OUT2         13'h12c2
`define COSS_TIME_EV1        13'h12d1
`define COSS_TIME_EV2        13'h12d2
`define COSS_TIME_EV3        13'h12d3
`define COSS_TIME_EV4        13'h12d5
`define COSS_ALM1            13'h10e1
`define COSS_ALM2            13'h10e2
`define COSS_ALM_OUT1        13'h1101
`define COSS_ALM_OUT2        13'h1102
`define COSS_LAT1_A1         13'h1121
`define COSS_LAT1_A2         13'h1122
`define COSS_LAT2_A1         13'h1141
`define COSS_LAT2_A2         13'h1142
`define COSS_LAT3_A1         13'h1161
`define COSS_LAT3_A2         13'h1162
`define COSS_LAT4_A1         13'h1181
`define COSS_LAT4_A2         13'h1182
`define COSS_KEY_A_FIRST     13'h1261
`define COSS_KEY_A_LAST      13'h1267
`define COSS_KEY_B_FIRST     13'h126c
`define COSS_KEY_B_LAST      13'h126f
`define COSS_MAN             13'h1051
`define COSS_MODE_RESET      13'h1055
`define COSS_MODE_RUN        13'h1056
`define COSS_MODE_LOCAL      13'h1057
`define COSS_MODE_HOLD       13'h105d
`define COSS_WAIT_FLAG       13'h105e
`define COSS_TUNING          13'h105f
`define COSS_VALVE_ADJ       13'h1071
`define COSS_VALVE_EST       13'h1072
`define COSS_VALVE_OPEN      13'h1075
`define COSS_VALVE_CLOSED    13'h1076
`define COSS_FAIL_NORMAL     13'h10a0
`define COSS_WAIT_END_1S     13'h10a1
`define COSS_WAIT_END_3S     13'h10a2
`define COSS_WAIT_END_5S     13'h10a3
`define COSS_SEG_FLAG        13'h10a5
`define COSS_PAT_END_1S      13'h10a9
`define COSS_PAT_END_3S      13'h10aa
`define COSS_PAT_END_5S      13'h10ab

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define COSS_CLK_KHZ         20000
`define COSS_PULSE_A_MS      1000
`define COSS_PULSE_B_MS      3000
`define COSS_PULSE_C_MS      5000
`define COSS_CNT_W           27
`define COSS_PULSE_A_CYC     27'h131_2d00
`define COSS_PULSE_B_CYC     27'h393_8700
`define COSS_PULSE_C_CYC     27'h5f5_e100

`endif

//--- coss_field_relays.sv
// Field relay model: each coil follows its contact one clock later.
// Assumes contacts are registered outputs of the selector.
`timescale 1ns/1ns
module coss_field_relays (
  input  wire        clk_sys,
  input  wire [24:0] contact,
  output reg  [24:0] coil_on
);
  // Armature lags the contact by a cycle, as a slow relay would
  always @(posedge clk_sys) begin
    coil_on <= contact;
  end
endmodule // coss_field_relays

//--- coss_sel_checker.sv
// Checker for the contact output status selector: bus timing, duty relays,
// unfitted areas and the state after reset.
// Assumes it is bound to coss_selector with hready fed from hreadyout.
`timescale 1ns/1ns
module coss_sel_checker (
  input wire        clk_sys,
  input wire        rst_n,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire        hreadyout,
  input wire        hresp,
  input wire [3:0]  area_fitted,
  input wire [1:0]  control_duty,
  input wire [1:0]  control_drive,
  input wire [2:0]  std_contact,
  input wire [19:0] extra_contact,
  input wire [1:0]  control_contact
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // Request accepted at this edge
  wire taken = hsel & hready & htrans[1];

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  read_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  write_fast_a: assert property (taken && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  // Relay on control duty follows the drive level, polarity ignored
  duty_one_a: assert property ($past(rst_n) && $past(control_duty[0]) |->
    control_contact[0] == $past(control_drive[0])) else $error("relay one off drive");
  duty_two_a: assert property ($past(rst_n) && $past(control_duty[1]) |->
    control_contact[1] == $past(control_drive[1])) else $error("relay two off drive");
  // An area that is not fitted keeps all five contacts open
  area_one_a: assert property ($past(rst_n) && !$past(area_fitted[0]) |->
    extra_contact[4:0] == 5'h00) else $error("unfitted area one driven");
  area_four_a: assert property ($past(rst_n) && !$past(area_fitted[3]) |->
    extra_contact[19:15] == 5'h00) else $error("unfitted area four driven");
  // Unassigned selections after reset must leave standard and extra contacts open
  reset_open_a: assert property ($rose(rst_n) |=>
    std_contact == 3'h0 && extra_contact == 20'h0_0000) else $error("contact closed at reset");
endmodule // coss_sel_checker

bind coss_selector coss_sel_checker i_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .area_fitted(area_fitted), .control_duty(control_duty),
  .control_drive(control_drive), .std_contact(std_contact),
  .extra_contact(extra_contact), .control_contact(control_contact)
);

//--- coss_selector.v
// Contact output status selector: 25 relay contacts, each driven by one
// internal status source picked by its code, with per-output polarity.
// Assumes status inputs synchronous to clk_sys and an AHB-Lite master
// doing single whole-word transfers.
`timescale 1ns/1ns
`include "coss_consts.vh"

// Notes on behaviour
// - Each contact follows the one status source its selection code names, unless its area is unfitted or it is a control relay on control duty.
// - Five extra outputs per terminal area, areas one to four, own settings.
// - Control relays carry a selected status when not on control duty.
// - Energized type: contact on while selected event holds, off otherwise.
// - Process value event internal status 1 and 2 at codes 4785, 4786.
// - Process value event output status 1 and 2 at codes 4801, 4802.
// - Time events 1 to 4 at 4817, 4818, 4819, 4821; gap before fourth.
// - Internal alarm status 1 and 2 at codes 4321, 4322.
// - Alarm output status 1 and 2 at 4353, 4354, shaped by alarm settings.
// - Four latch sources per alarm, selectable whatever the alarm type.
// - Latch source on while latched, off once released; polarity applies.
// - One source per front key, on while that key is pressed.
// - Mode sources for reset, run, local and hold operation.
// - Pattern end pulses sources 4265, 4266, 4267 for 1, 3, 5 seconds.
// - Wait end pulses sources 4257, 4258, 4259 for 1, 3, 5 seconds.
// - Wait flag and segment flag set on wait, clear on wait release.
// - Valve sources: adjusting, estimating mode, open, closed.
// - Polarity 0 closes contact on event, polarity 1 opens it.
module coss_selector #(
  // Pulse lengths in clock cycles
  parameter [`COSS_CNT_W-1:0] PULSE_A_CYC = `COSS_PULSE_A_CYC,
  parameter [`COSS_CNT_W-1:0] PULSE_B_CYC = `COSS_PULSE_B_CYC,
  parameter [`COSS_CNT_W-1:0] PULSE_C_CYC = `COSS_PULSE_C_CYC
) (
  input  wire                    clk_sys,
  input  wire                    rst_n,
  // Register bus
  input  wire                    hsel,
  input  wire [31:0]             haddr,
  input  wire [1:0]              htrans,
  input  wire                    hwrite,
  input  wire [2:0]              hsize,
  input  wire [31:0]             hwdata,
  input  wire                    hready,
  output wire                    hreadyout,
  output wire                    hresp,
  output reg  [31:0]             hrdata,
  // Status sources
  input  wire [1:0]              pv_event_status,
  input  wire [1:0]              pv_event_output_status,
  input  wire [3:0]              time_event_status,
  input  wire [1:0]              alarm_status,
  input  wire [1:0]              alarm_output_status,
  input  wire [7:0]              alarm_latch_status,
  input  wire [10:0]             key_pressed,
  input  wire [3:0]              mode_entered,
  input  wire                    manual_mode,
  input  wire                    auto_tuning_active,
  input  wire                    pattern_end_pulse,
  input  wire                    wait_end_pulse,
  input  wire                    wait_cmd,
  input  wire                    wait_release_cmd,
  input  wire                    valve_adjusting,
  input  wire                    valve_estimating,
  input  wire                    valve_open,
  input  wire                    valve_closed,
  input  wire                    fail_normal,
  // Terminal areas and control relay duty
  input  wire [3:0]              area_fitted,
  input  wire [1:0]              control_duty,
  input  wire [1:0]              control_drive,
  // Relay contacts, 1 = closed
  output wire [2:0]              std_contact,
  output wire [19:0]             extra_contact,
  output wire [1:0]              control_contact
);

  // ----------------------------------------------------------------------
  // Code lookup
  // ----------------------------------------------------------------------
  // Returns {known, level}; unknown codes give {0,0}
  // Key runs are checked after the case and override it
  function [1:0] coss_pick;
    input [`COSS_CODE_W-1:0] code;
    input [`COSS_NUM_SRC-1:0] src;
    reg   [`COSS_CODE_W-1:0] ofs;
    begin
      coss_pick = 2'b00;
      ofs = `COSS_SEL_RESET;
      case (code)
        // Process value, time and alarm sources
        `COSS_PV_EV1:       coss_pick = {1'b1, src[0]};
        `COSS_PV_EV2:       coss_pick = {1'b1, src[1]};
        `COSS_PV_OUT1:      coss_pick = {1'b1, src[2]};
        `COSS_PV_OUT2:      coss_pick = {1'b1, src[3]};
        `COSS_TIME_EV1:     coss_pick = {1'b1, src[4]};
        `COSS_TIME_EV2:     coss_pick = {1'b1, src[5]};
        `COSS_TIME_EV3:     coss_pick = {1'b1, src[6]};
        `COSS_TIME_EV4:     coss_pick = {1'b1, src[7]};
        `COSS_ALM1:         coss_pick = {1'b1, src[8]};
        `COSS_ALM2:         coss_pick = {1'b1, src[9]};
        `COSS_ALM_OUT1:     coss_pick = {1'b1, src[10]};
        `COSS_ALM_OUT2:     coss_pick = {1'b1, src[11]};
        `COSS_LAT1_A1:      coss_pick = {1'b1, src[12]};
        `COSS_LAT1_A2:      coss_pick = {1'b1, src[13]};
        `COSS_LAT2_A1:      coss_pick = {1'b1, src[14]};
        `COSS_LAT2_A2:      coss_pick = {1'b1, src[15]};
        `COSS_LAT3_A1:      coss_pick = {1'b1, src[16]};
        `COSS_LAT3_A2:      coss_pick = {1'b1, src[17]};
        `COSS_LAT4_A1:      coss_pick = {1'b1, src[18]};
        `COSS_LAT4_A2:      coss_pick = {1'b1, src[19]};
        // Mode, pulse, flag and valve sources
        `COSS_MODE_RESET:   coss_pick = {1'b1, src[31]};
        `COSS_MODE_RUN:     coss_pick = {1'b1, src[32]};
        `COSS_MODE_LOCAL:   coss_pick = {1'b1, src[33]};
        `COSS_MODE_HOLD:    coss_pick = {1'b1, src[34]};
        `COSS_MAN:          coss_pick = {1'b1, src[35]};
        `COSS_TUNING:       coss_pick = {1'b1, src[36]};
        `COSS_PAT_END_1S:   coss_pick = {1'b1, src[37]};
        `COSS_PAT_END_3S:   coss_pick = {1'b1, src[38]};
        `COSS_PAT_END_5S:   coss_pick = {1'b1, src[39]};
        `COSS_WAIT_END_1S:  coss_pick = {1'b1, src[40]};
        `COSS_WAIT_END_3S:  coss_pick = {1'b1, src[41]};
        `COSS_WAIT_END_5S:  coss_pick = {1'b1, src[42]};
        `COSS_WAIT_FLAG:    coss_pick = {1'b1, src[43]};
        `COSS_SEG_FLAG:     coss_pick = {1'b1, src[44]};
        `COSS_VALVE_ADJ:    coss_pick = {1'b1, src[45]};
        `COSS_VALVE_EST:    coss_pick = {1'b1, src[46]};
        `COSS_VALVE_OPEN:   coss_pick = {1'b1, src[47]};
        `COSS_VALVE_CLOSED: coss_pick = {1'b1, src[48]};
        `COSS_FAIL_NORMAL:  coss_pick = {1'b1, src[49]};
        default:            coss_pick = 2'b00;
      endcase
      // Keys sit in two consecutive runs of codes
      if (code >= `COSS_KEY_A_FIRST && code <= `COSS_KEY_A_LAST) begin
        ofs = code - `COSS_KEY_A_FIRST;
        coss_pick = {1'b1, src[20 + ofs[2:0]]};
      end else if (code >= `COSS_KEY_B_FIRST && code <= `COSS_KEY_B_LAST) begin
        ofs = code - `COSS_KEY_B_FIRST;
        coss_pick = {1'b1, src[27 + ofs[1:0]]};
      end
    end
  endfunction

  // Pulse window test shared by all six timed sources
  function coss_within;
    input                    run;
    input [`COSS_CNT_W-1:0]  cnt;
    input [`COSS_CNT_W-1:0]  lim;
    begin
      coss_within = run && (cnt < lim);
    end
  endfunction

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  // Settings written over the bus
  reg  [`COSS_CODE_W-1:0]  sel [0:`COSS_NUM_OUT-1];
  reg  [`COSS_NUM_OUT-1:0] polarity;
  // Registered contact levels
  reg  [`COSS_NUM_OUT-1:0] contact;
  // Pulse timers and wait flags
  reg  [`COSS_CNT_W-1:0]   pat_cnt;
  reg                      pat_run;
  reg  [`COSS_CNT_W-1:0]   wend_cnt;
  reg                      wend_run;
  reg                      wait_flag;
  reg                      seg_flag;
  // Bus phase state
  reg                      ap_write;
  reg  [`COSS_ADDR_W-1:0]  ap_addr;
  reg                      rd_wait;
  reg  [`COSS_ADDR_W-1:0]  rd_addr;
  wire [`COSS_NUM_SRC-1:0] src;
  wire                     ap_take;
  wire [`COSS_ADDR_W-1:0]  wr_idx;
  // One loop index per process
  integer                  i;
  integer                  j;

  // ----------------------------------------------------------------------
  // Source vector
  // ----------------------------------------------------------------------
  // Order here must match the indices used by coss_pick
  // Each pulse length is a compare against the shared count
  assign src = {fail_normal, valve_closed, valve_open, valve_estimating,
                valve_adjusting, seg_flag, wait_flag,
                coss_within(wend_run, wend_cnt, PULSE_C_CYC),
                coss_within(wend_run, wend_cnt, PULSE_B_CYC),
                coss_within(wend_run, wend_cnt, PULSE_A_CYC),
                coss_within(pat_run, pat_cnt, PULSE_C_CYC),
                coss_within(pat_run, pat_cnt, PULSE_B_CYC),
                coss_within(pat_run, pat_cnt, PULSE_A_CYC),
                auto_tuning_active, manual_mode, mode_entered,
                key_pressed, alarm_latch_status, alarm_output_status,
                alarm_status, time_event_status, pv_event_output_status,
                pv_event_status};

  // ----------------------------------------------------------------------
  // Timed pulses
  // ----------------------------------------------------------------------
  // One counter serves all three lengths; a new end event restarts it
  // Limitation: a restart also retriggers the shorter pulses that had already ended
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pat_cnt  <= {`COSS_CNT_W{1'b0}};
      pat_run  <= 1'b0;
      wend_cnt <= {`COSS_CNT_W{1'b0}};
      wend_run <= 1'b0;
    end else begin
      if (pattern_end_pulse) begin
        pat_cnt <= {`COSS_CNT_W{1'b0}};
        pat_run <= 1'b1;
      end else if (pat_run) begin
        if (pat_cnt == PULSE_C_CYC - 1'b1)
          pat_run <= 1'b0;
        else
          pat_cnt <= pat_cnt + 1'b1;
      end
      if (wait_end_pulse) begin
        wend_cnt <= {`COSS_CNT_W{1'b0}};
        wend_run <= 1'b1;
      end else if (wend_run) begin
        if (wend_cnt == PULSE_C_CYC - 1'b1)
          wend_run <= 1'b0;
        else
          wend_cnt <= wend_cnt + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wait flags
  // ----------------------------------------------------------------------
  // A wait command in the release cycle wins, so no wait is lost
  // Both flags move together; only their codes differ
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wait_flag <= 1'b0;
      seg_flag  <= 1'b0;
    end else if (wait_cmd) begin
      wait_flag <= 1'b1;
      seg_flag  <= 1'b1;
    end else if (wait_release_cmd) begin
      wait_flag <= 1'b0;
      seg_flag  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Contact outputs
  // ----------------------------------------------------------------------
  // Index 0..2 standard, 3..22 extra (five per area), 23..24 control
  // Later loops override: area gating, then control duty
  // Registered, so a contact lags its source by one clock
  always @(posedge clk_sys or negedge rst_n) begin : contact_eval
    reg [1:0] pick;
    if (!rst_n) begin
      contact <= {`COSS_NUM_OUT{1'b0}};
    end else begin
      for (i = 0; i < `COSS_NUM_OUT; i = i + 1) begin
        pick = coss_pick(sel[i], src);
        // Polarity only flips a known source; unknown stays open
        contact[i] <= pick[1] & (pick[0] ^ polarity[i]);
      end
      for (i = 0; i < 20; i = i + 1) begin
        if (!area_fitted[i / 5])
          contact[3 + i] <= 1'b0;
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (control_duty[i])
          contact[23 + i] <= control_drive[i];
      end
    end
  end

  // Split the contact word into its three output groups
  assign std_contact     = contact[2:0];
  assign extra_contact   = contact[22:3];
  assign control_contact = contact[24:23];

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  // Reads take one wait state so a write just before is always seen
  // No access is refused, so the response stays OKAY
  assign ap_take   = hsel && hready && htrans[1];
  assign hreadyout = ~rd_wait;
  assign hresp     = 1'b0;
  assign wr_idx    = (ap_addr - `COSS_SEL_BASE) >> 2;

  // Address phase capture and read data
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ap_write <= 1'b0;
      ap_addr  <= {`COSS_ADDR_W{1'b0}};
      rd_wait  <= 1'b0;
      rd_addr  <= {`COSS_ADDR_W{1'b0}};
      hrdata   <= 32'h0000_0000;
    end else begin
      ap_write <= ap_take && hwrite;
      if (ap_take)
        ap_addr <= haddr[`COSS_ADDR_W-1:0];
      rd_wait <= ap_take && !hwrite;
      if (ap_take && !hwrite)
        rd_addr <= haddr[`COSS_ADDR_W-1:0];
      // Only low address bits decode, so the map repeats
      if (rd_wait) begin
        if (rd_addr <= `COSS_SEL_LAST && rd_addr[1:0] == 2'b00)
          hrdata <= {19'h0_0000, sel[rd_addr[6:2]]};
        else if (rd_addr == `COSS_POL_ADDR)
          hrdata <= {7'h00, polarity};
        else if (rd_addr == `COSS_CONTACT_ADDR)
          hrdata <= {7'h00, contact};
        else if (rd_addr == `COSS_SRC_LO_ADDR)
          hrdata <= src[31:0];
        else if (rd_addr == `COSS_SRC_HI_ADDR)
          hrdata <= {14'h0000, src[49:32]};
        else
          hrdata <= 32'h0000_0000;
      end
    end
  end

  // Register writes in the data phase; unmapped writes are dropped
  // Unaligned selection writes are ignored as well
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      polarity <= `COSS_POL_RESET;
      for (j = 0; j < `COSS_NUM_OUT; j = j + 1)
        sel[j] <= `COSS_SEL_RESET;
    end else if (ap_write) begin
      if (ap_addr <= `COSS_SEL_LAST && ap_addr[1:0] == 2'b00)
        sel[wr_idx[4:0]] <= hwdata[`COSS_CODE_W-1:0];
      else if (ap_addr == `COSS_POL_ADDR)
        polarity <= hwdata[`COSS_NUM_OUT-1:0];
    end
  end

endmodule // coss_selector

//--- tb.sv
// Testbench for the contact output status selector over AHB-Lite.
// Assumes coss_consts.vh on the include path; pulse counts are shortened.
`timescale 1ns/1ns
`include "coss_consts.vh"
module tb;
  localparam PA = 10;
  localparam PB = 30;
  localparam PC = 50;
  reg         clk_sys;
  reg         rst_n;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  reg  [49:0] src;
  reg         pat_end;
  reg         wait_end;
  reg         wait_set;
  reg         wait_clr;
  reg  [3:0]  area_fitted;
  reg  [1:0]  duty;
  reg  [1:0]  drive;
  wire        hready;
  wire [31:0] hrdata;
  wire [2:0]  std_contact;
  wire [19:0] extra_contact;
  wire [1:0]  control_contact;
  wire [24:0] coil_on;
  reg  [31:0] rd;
  int         miscompares;
  int         check_count;
  int         i;
  int         k;
  int         n [3];

  coss_selector #(.PULSE_A_CYC(PA), .PULSE_B_CYC(PB), .PULSE_C_CYC(PC)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
    .pv_event_status(src[1:0]), .pv_event_output_status(src[3:2]),
    .time_event_status(src[7:4]), .alarm_status(src[9:8]),
    .alarm_output_status(src[11:10]), .alarm_latch_status(src[19:12]),
    .key_pressed(src[30:20]), .mode_entered(src[34:31]), .manual_mode(src[35]),
    .auto_tuning_active(src[36]), .pattern_end_pulse(pat_end),
    .wait_end_pulse(wait_end), .wait_cmd(wait_set), .wait_release_cmd(wait_clr),
    .valve_adjusting(src[45]), .valve_estimating(src[46]), .valve_open(src[47]),
    .valve_closed(src[48]), .fail_normal(src[49]), .area_fitted(area_fitted),
    .control_duty(duty), .control_drive(drive), .std_contact(std_contact),
    .extra_contact(extra_contact), .control_contact(control_contact)
  );
  coss_field_relays i_relays (.clk_sys(clk_sys),
    .contact({control_contact, extra_contact, std_contact}), .coil_on(coil_on));

  // 20 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Bounded wait for hready; a stuck bus ends the run
  task automatic wait_ready;
    int t;
    t = 0;
    @(posedge clk_sys);
    while (hready !== 1'b1) begin
      t++;
      if (t > 20) begin
        $display("ERROR hready expected 1 seen %b", hready);
        miscompares++;
        stop_test;
      end
      @(posedge clk_sys);
    end
  endtask

  // One single word transfer; read data lands in rd
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    wait_ready;
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready;
    rd = hrdata;
  endtask

  // Selection code of each level source, by source vector index
  function automatic logic [12:0] code_of(input int j);
    int c;
    if (j < 2) c = 4785 + j;
    else if (j < 4) c = 4799 + j;
    else if (j < 7) c = 4813 + j;
    else if (j == 7) c = 4821;
    else if (j < 10) c = 4313 + j;
    else if (j < 12) c = 4343 + j;
    else if (j < 20) c = 4385 + 32 * ((j - 12) / 2) + (j % 2);
    else if (j < 27) c = 4685 + j;
    else if (j < 31) c = 4689 + j;
    else if (j < 34) c = 4150 + j;
    else if (j == 34) c = 4189;
    else if (j == 35) c = 4177;
    else if (j == 36) c = 4191;
    else if (j < 47) c = 4164 + j;
    else if (j < 49) c = 4166 + j;
    else c = 4256;
    return c[12:0];
  endfunction

  initial begin
    rst_n = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = 50'h0;
    pat_end = 1'b0;
    wait_end = 1'b0;
    wait_set = 1'b0;
    wait_clr = 1'b0;
    area_fitted = 4'hf;
    duty = 2'b00;
    drive = 2'b00;
    miscompares = 0;
    check_count = 0;
    tick(16);
    rst_n <= 1'b1;
    tick(1);
    // Reset values, unmapped place, read back
    ahb(1'b0, 32'h0000_0080, 32'h0);
    chk("polarity reset", 32'h0, rd);
    ahb(1'b1, 32'h0000_00a0, 32'hffff_ffff);
    ahb(1'b0, 32'h0000_00a0, 32'h0);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, 32'h0000_0060, 32'h0000_1fff);
    ahb(1'b0, 32'h0000_0060, 32'h0);
    chk("relay two select", 32'h0000_1fff, rd);
    $display("registers done");
    // Every level source through standard output one
    for (i = 0; i < 50; i++) begin
      if (i > 36 && i < 45) continue;
      ahb(1'b1, 32'h0, {19'h0, code_of(i)});
      tick(3);
      chk($sformatf("source %0d idle", i), 32'h0, {29'h0, std_contact});
      src[i] <= 1'b1;
      tick(3);
      chk($sformatf("source %0d on", i), 32'h1, {29'h0, std_contact});
      src[i] <= 1'b0;
    end
    $display("sources done");
    // Inverted contact on standard output two
    ahb(1'b1, 32'h0000_0004, {19'h0, `COSS_ALM1});
    ahb(1'b1, 32'h0000_0080, 32'h0000_0002);
    tick(3);
    chk("inverted idle", 32'h0000_0002, {29'h0, std_contact});
    ahb(1'b0, 32'h0000_0084, 32'h0);
    chk("contact register", 32'h0000_0002, rd);
    chk("field coil", 32'h0000_0002, {7'h0, coil_on});
    src[8] <= 1'b1;
    tick(3);
    chk("inverted event", 32'h0, {29'h0, std_contact});
    // Code in the gap between time events stays open even when inverted
    ahb(1'b1, 32'h0000_0008, {19'h0, 13'h12d4});
    ahb(1'b1, 32'h0000_0080, 32'h0000_0004);
    src <= {42'h0, 4'hf, 4'h0};
    tick(3);
    chk("gap code", 32'h0, {29'h0, std_contact});
    $display("polarity done");
    // Pattern end and wait end pulses on area one outputs
    ahb(1'b1, 32'h0000_0080, 32'h0);
    for (k = 0; k < 2; k++) begin
      for (i = 0; i < 3; i++)
        ahb(1'b1, 32'h0000_000c + 4 * i,
            {19'h0, (k ? `COSS_WAIT_END_1S : `COSS_PAT_END_1S) + i[12:0]});
      n = '{0, 0, 0};
      if (k == 1)
        wait_end <= 1'b1;
      else
        pat_end <= 1'b1;
      tick(1);
      pat_end <= 1'b0;
      wait_end <= 1'b0;
      repeat (70) begin
        tick(1);
        for (i = 0; i < 3; i++) n[i] += extra_contact[i];
      end
      chk("pulse short", PA, n[0]);
      chk("pulse middle", PB, n[1]);
      chk("pulse long", PC, n[2]);
    end
    $display("pulses done");
    // Wait flag and segment flag
    ahb(1'b1, 32'h0, {19'h0, `COSS_WAIT_FLAG});
    ahb(1'b1, 32'h0000_0004, {19'h0, `COSS_SEG_FLAG});
    wait_set <= 1'b1;
    tick(1);
    wait_set <= 1'b0;
    tick(3);
    chk("flags set", 32'h3, {29'h0, std_contact});
    wait_clr <= 1'b1;
    tick(1);
    wait_clr <= 1'b0;
    tick(3);
    chk("flags clear", 32'h0, {29'h0, std_contact});
    $display("wait flags done");
    // Terminal areas and control relays
    src <= 50'h1;
    ahb(1'b1, 32'h0000_0048, {19'h0, `COSS_PV_EV1});
    ahb(1'b1, 32'h0000_0060, {19'h0, `COSS_PV_EV1});
    ahb(1'b1, 32'h0000_000c, {19'h0, `COSS_PV_EV1});
    area_fitted <= 4'h6;
    tick(3);
    chk("unfitted area", 32'h0, {12'h0, extra_contact});
    area_fitted <= 4'hf;
    tick(3);
    chk("fitted area", 32'h0000_8001, {12'h0, extra_contact});
    chk("relay status", 32'h2, {30'h0, control_contact});
    ahb(1'b0, 32'h0000_0088, 32'h0);
    chk("source low word", 32'h1, rd);
    duty <= 2'b11;
    drive <= 2'b01;
    tick(3);
    chk("relay duty", 32'h1, {30'h0, control_contact});
    $display("areas and relays done");
    stop_test;
  end
endmodule // tb
